// *** common/kbs_pkg.sv ***
// constants, field layout and state type of the two-wire shift engine
package kbs_pkg;
  // register indices on the plain register port
  localparam logic [2:0] ADDR_BYTE = 3'h0; // shift_byte_register
  localparam logic [2:0] ADDR_STATUS = 3'h1; // shift_status_register, read only
  localparam logic [2:0] ADDR_CONTROL = 3'h2; // shift_control_register
  localparam logic [2:0] ADDR_OUTCTL = 3'h3; // line_output_control
  localparam logic [2:0] ADDR_INREAD = 3'h4; // line_input_readback, read only
  localparam logic [2:0] ADDR_IRQEN = 3'h5; // shift_irq_enables
  // control register fields
  localparam int CTL_ENABLE = 0; // engine enable
  localparam int CTL_XMT = 1; // direction_transmit_bit
  // status register fields
  localparam int ST_START = 0; // start_seen_flag
  localparam int ST_DONE = 1; // transfer_done_flag
  localparam int ST_PARITY_ERROR_FLAG = 2; // parity_error_flag
  localparam int ST_ACH_LO = 3; // active_channel_field low bit
  localparam int ST_STOP_LOW_ERROR_FLAG = 6; // stop_low_error_flag
  // output control fields: data outs in [2:0], clock enables in [5:3]
  localparam int OUT_DATA_LO = 0;
  localparam int OUT_CLK_LO = 3;
  // irq enable fields
  localparam int IE_START = 0; // start_flag_irq_enable
  localparam int IE_END = 1; // end_flag_irq_enable
  localparam int IE_DIRECT = 2; // direct_mode_irq_enable
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_OUTCTL = 8'h07;
  localparam logic [7:0] RST_IRQEN = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;
  // falling-edge indices after the start bit (0 is first after start)
  localparam logic [3:0] RX_PAR_EDGE = 4'h8; // 10th clock overall
  localparam logic [3:0] RX_STOP_EDGE = 4'h9; // 11th clock overall
  localparam logic [3:0] TX_LAST_DATA = 4'h6; // drives bit 7
  localparam logic [3:0] TX_PAR_EDGE = 4'h7; // ninth fall overall
  localparam logic [3:0] TX_STOP_EDGE = 4'h8; // tenth fall overall
  localparam logic [3:0] TX_LC_EDGE = 4'h9; // 11th fall overall
  // engine states
  typedef enum logic [2:0] {
    KBS_OFF, KBS_INACTIVE, KBS_IDLE, KBS_ACTIVE, KBS_END
  } kbs_state_t;
endpackage : kbs_pkg

// *** rtl/kbs_shifter.sv ***
// three-channel two-wire keyboard/mouse shift engine with direct pin mode
// Notes on behaviour
// - engine irq is level, gated per flag enable
// - receive enable goes inactive, channel enable idles
// - idle picks first starter, others clocks low
// - start bit: clock falls while data low
// - simultaneous starts: lowest channel wins, others aborted
// - receive start sets flag, channel, irq
// - receive samples data on selected clock falls
// - low stop sets frame error, still ends
// - even ones over data plus parity: error
// - stop enters end: clocks low, flag, irq
// - transmit enable: inactive, clocks low, data high
// - transmit idle releases target clock, others low
// - transmit start drives bit0, sets data outs
// - bits 1-7 then odd parity on ninth
// - tenth fall drives stop high, data released
// - line-control bit low ends transmission
// - all channel enables clear aborts to inactive
// - disabled: control bits drive pins directly
// - disabled with direct irq: clocks to irqs
// - least significant bit first both directions
// - active channel field is one-hot
`timescale 1ns/10ps
module kbs_shifter (
  input wire logic clk,
  input wire logic rst,
  input wire logic [2:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic [2:0] chan_clock_pin_in,
  output logic [2:0] chan_clock_pin_out,
  output logic [2:0] chan_clock_pin_oe,
  input wire logic [2:0] chan_data_pin_in,
  output logic [2:0] chan_data_pin_out,
  output logic [2:0] chan_data_pin_oe,
  output logic shifter_irq_line,
  output logic chan2_edge_irq,
  output logic chan3_edge_irq
);

  // lowest set bit as a one-hot vector
  function automatic logic [2:0] first_one(input logic [2:0] v);
    first_one = v[0] ? 3'h1 : (v[1] ? 3'h2 : (v[2] ? 3'h4 : 3'h0));
  endfunction : first_one

  // software registers
  logic [7:0] shift_byte_register; // data to send or byte received
  logic [7:0] shift_control_register;
  logic [7:0] line_output_control;
  logic [7:0] shift_irq_enables;
  // status fields
  logic start_seen_flag;
  logic transfer_done_flag;
  logic parity_error_flag;
  logic stop_low_error_flag;
  logic [2:0] active_channel_field;
  // engine state
  kbs_pkg::kbs_state_t state;
  logic [3:0] edge_cnt; // falls of the selected clock since start
  logic [7:0] shifter; // bit shifter, rx fills from the top
  logic tx_bit; // level driven on the selected data line
  logic tx_par; // odd parity of the byte being sent
  // pin synchronisers, first stage read only by second
  logic [2:0] clk_meta;
  logic [2:0] clk_sync;
  logic [2:0] clk_prev;
  logic [2:0] dat_meta;
  logic [2:0] dat_sync;

  // decode wires
  wire ctl_en = shift_control_register[kbs_pkg::CTL_ENABLE];
  wire ctl_xmt = shift_control_register[kbs_pkg::CTL_XMT];
  wire [2:0] wdat = line_output_control[kbs_pkg::OUT_DATA_LO +: 3];
  wire [2:0] clken = line_output_control[kbs_pkg::OUT_CLK_LO +: 3];
  wire ie_start = shift_irq_enables[kbs_pkg::IE_START];
  wire ie_end = shift_irq_enables[kbs_pkg::IE_END];
  wire ie_direct = shift_irq_enables[kbs_pkg::IE_DIRECT];
  wire abort = ~|clken;
  wire [2:0] clk_fall = clk_prev & ~clk_sync;
  wire [2:0] start_hits = clk_fall & ~dat_sync & clken;
  wire [2:0] start_sel = first_one(start_hits);
  wire sel_fall = |(clk_fall & active_channel_field);
  wire sel_data = |(dat_sync & active_channel_field);
  wire in_idle = (state == kbs_pkg::KBS_IDLE);
  wire in_active = (state == kbs_pkg::KBS_ACTIVE);
  wire start_take = ctl_en & ~abort & in_idle & (|start_hits);
  wire active_fall = ctl_en & ~abort & in_active & sel_fall;
  wire rx_stop = active_fall & ~ctl_xmt & (edge_cnt == kbs_pkg::RX_STOP_EDGE);
  wire tx_lc = active_fall & ctl_xmt & (edge_cnt == kbs_pkg::TX_LC_EDGE) & ~sel_data;
  wire [7:0] status_word = {1'b0, stop_low_error_flag, active_channel_field,
                            parity_error_flag, transfer_done_flag, start_seen_flag};

  // two-flop synchronisers and edge history
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clk_meta <= 3'h7;
      clk_sync <= 3'h7;
      clk_prev <= 3'h7;
      dat_meta <= 3'h7;
      dat_sync <= 3'h7;
    end else begin
      clk_meta <= chan_clock_pin_in;
      clk_sync <= clk_meta;
      clk_prev <= clk_sync;
      dat_meta <= chan_data_pin_in;
      dat_sync <= dat_meta;
    end
  end

  // software writes; hardware sets data outs on transmit start
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_control_register <= kbs_pkg::RST_CONTROL;
      line_output_control <= kbs_pkg::RST_OUTCTL;
      shift_irq_enables <= kbs_pkg::RST_IRQEN;
    end else begin
      if (reg_wr && reg_addr == kbs_pkg::ADDR_CONTROL) begin
        shift_control_register <= reg_wdata;
      end
      if (reg_wr && reg_addr == kbs_pkg::ADDR_IRQEN) begin
        shift_irq_enables <= reg_wdata;
      end
      // hardware set beats a same-cycle firmware write of the data outs
      if (start_take && ctl_xmt) begin
        line_output_control <= {2'b00, (reg_wr && reg_addr == kbs_pkg::ADDR_OUTCTL)
                                ? reg_wdata[5:3] : clken, 3'h7};
      end else if (reg_wr && reg_addr == kbs_pkg::ADDR_OUTCTL) begin
        line_output_control <= {2'b00, reg_wdata[5:0]};
      end
    end
  end

  // engine state machine
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= kbs_pkg::KBS_OFF;
    end else if (!ctl_en) begin
      state <= kbs_pkg::KBS_OFF;
    end else if (abort) begin
      state <= kbs_pkg::KBS_INACTIVE;
    end else begin
      case (state)
        kbs_pkg::KBS_OFF: state <= kbs_pkg::KBS_IDLE; // enabled with a channel already on
        kbs_pkg::KBS_INACTIVE: state <= kbs_pkg::KBS_IDLE;
        kbs_pkg::KBS_IDLE: begin
          if (|start_hits) begin
            state <= kbs_pkg::KBS_ACTIVE;
          end
        end
        kbs_pkg::KBS_ACTIVE: begin
          if (rx_stop || tx_lc) begin
            state <= kbs_pkg::KBS_END;
          end
        end
        kbs_pkg::KBS_END: state <= kbs_pkg::KBS_END; // held until reset, disable or abort
        default: state <= kbs_pkg::KBS_OFF;
      endcase
    end
  end

  // status flags; cleared while disabled or aborted
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      start_seen_flag <= 1'b0;
      transfer_done_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      stop_low_error_flag <= 1'b0;
      active_channel_field <= 3'h0;
    end else if (!ctl_en || abort) begin
      start_seen_flag <= 1'b0;
      transfer_done_flag <= 1'b0;
      parity_error_flag <= 1'b0;
      stop_low_error_flag <= 1'b0;
      active_channel_field <= 3'h0;
    end else begin
      if (start_take) begin
        start_seen_flag <= 1'b1;
        active_channel_field <= start_sel;
      end
      if (active_fall && !ctl_xmt && edge_cnt == kbs_pkg::RX_PAR_EDGE) begin
        parity_error_flag <= ~(^shifter ^ sel_data);
      end
      if (rx_stop) begin
        stop_low_error_flag <= ~sel_data;
      end
      if (rx_stop || tx_lc) begin
        transfer_done_flag <= 1'b1;
      end
    end
  end

  // bit counter and shifter, least significant bit first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      edge_cnt <= 4'h0;
      shifter <= 8'h00;
      tx_bit <= 1'b1;
      tx_par <= 1'b1;
    end else if (start_take) begin
      edge_cnt <= 4'h0;
      shifter <= shift_byte_register;
      tx_bit <= shift_byte_register[0];
      tx_par <= ~^shift_byte_register;
    end else if (active_fall) begin
      edge_cnt <= edge_cnt + 4'h1;
      if (!ctl_xmt && edge_cnt < kbs_pkg::RX_PAR_EDGE) begin
        shifter <= {sel_data, shifter[7:1]};
      end else if (ctl_xmt && edge_cnt <= kbs_pkg::TX_LAST_DATA) begin
        shifter <= {1'b0, shifter[7:1]};
        tx_bit <= shifter[1];
      end else if (ctl_xmt && edge_cnt == kbs_pkg::TX_PAR_EDGE) begin
        tx_bit <= tx_par;
      end else if (ctl_xmt && edge_cnt == kbs_pkg::TX_STOP_EDGE) begin
        tx_bit <= 1'b1;
      end
    end
  end

  // data register: firmware byte or received byte at the stop bit
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shift_byte_register <= kbs_pkg::RST_BYTE;
    end else if (rx_stop) begin
      shift_byte_register <= shifter;
    end else if (reg_wr && reg_addr == kbs_pkg::ADDR_BYTE) begin
      shift_byte_register <= reg_wdata;
    end
  end

  // pin drive: oe high pulls the open-drain line low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chan_clock_pin_oe <= 3'h0;
      chan_data_pin_oe <= 3'h0;
      chan_clock_pin_out <= 3'h0;
      chan_data_pin_out <= 3'h0;
    end else begin
      chan_clock_pin_out <= 3'h0;
      chan_data_pin_out <= 3'h0;
      case (state)
        kbs_pkg::KBS_IDLE: begin
          chan_clock_pin_oe <= ~clken;
          chan_data_pin_oe <= ~wdat; // rx keeps data outs high
        end
        kbs_pkg::KBS_ACTIVE: begin
          chan_clock_pin_oe <= ~active_channel_field;
          chan_data_pin_oe <= ctl_xmt ? (active_channel_field & {3{~tx_bit}}) : ~wdat;
        end
        kbs_pkg::KBS_END: begin
          chan_clock_pin_oe <= 3'h7;
          chan_data_pin_oe <= 3'h0;
        end
        default: begin
          chan_clock_pin_oe <= ~clken;
          chan_data_pin_oe <= ~wdat;
        end
      endcase
    end
  end

  // interrupt lines: shift mode uses line 1 only
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      shifter_irq_line <= 1'b0;
      chan2_edge_irq <= 1'b0;
      chan3_edge_irq <= 1'b0;
    end else if (ctl_en) begin
      shifter_irq_line <= (start_seen_flag & ie_start) | (transfer_done_flag & ie_end);
      chan2_edge_irq <= 1'b0;
      chan3_edge_irq <= 1'b0;
    end else begin
      // level copies; the interrupt controller finds the falling edges
      shifter_irq_line <= ie_direct & clk_sync[0];
      chan2_edge_irq <= ie_direct & clk_sync[1];
      chan3_edge_irq <= ie_direct & clk_sync[2];
    end
  end

  // read port: data the cycle after the strobe, zero when unmapped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        kbs_pkg::ADDR_BYTE: reg_rdata <= shift_byte_register;
        kbs_pkg::ADDR_STATUS: reg_rdata <= status_word;
        kbs_pkg::ADDR_CONTROL: reg_rdata <= shift_control_register;
        kbs_pkg::ADDR_OUTCTL: reg_rdata <= line_output_control;
        kbs_pkg::ADDR_INREAD: reg_rdata <= {2'b00, clk_sync, dat_sync};
        kbs_pkg::ADDR_IRQEN: reg_rdata <= shift_irq_enables;
        default: reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // checks
  property p_irq_end;
    @(posedge clk) disable iff (rst)
    (ctl_en && transfer_done_flag && ie_end) |=> shifter_irq_line;
  endproperty
  a_irq_end: assert property (p_irq_end) else $error("end irq missing");

  property p_start_take;
    @(posedge clk) disable iff (rst)
    start_take |=> (state == kbs_pkg::KBS_ACTIVE) && start_seen_flag
      && active_channel_field == $past(start_sel);
  endproperty
  a_start_take: assert property (p_start_take) else $error("start not taken");

  property p_priority;
    @(posedge clk) disable iff (rst)
    (start_take && start_hits[0]) |=> active_channel_field == 3'h1 ##1
      chan_clock_pin_oe[2:1] == 2'h3;
  endproperty
  a_priority: assert property (p_priority) else $error("priority wrong");

  property p_end_clocks;
    @(posedge clk) disable iff (rst)
    (state == kbs_pkg::KBS_END) |=> chan_clock_pin_oe == 3'h7 && chan_data_pin_oe == 3'h0;
  endproperty
  a_end_clocks: assert property (p_end_clocks) else $error("end pins wrong");

  property p_abort;
    @(posedge clk) disable iff (rst)
    (ctl_en && abort) |=> state == kbs_pkg::KBS_INACTIVE && status_word == 8'h00;
  endproperty
  a_abort: assert property (p_abort) else $error("abort failed");

  property p_parity;
    @(posedge clk) disable iff (rst)
    (active_fall && !ctl_xmt && edge_cnt == kbs_pkg::RX_PAR_EDGE)
      |=> parity_error_flag == ~($past(shifter[0]) ^ ^$past(shifter[7:1]) ^ $past(sel_data));
  endproperty
  a_parity: assert property (p_parity) else $error("parity flag wrong");

  property p_frame;
    @(posedge clk) disable iff (rst)
    (rx_stop && !sel_data) |=> stop_low_error_flag && transfer_done_flag
      && state == kbs_pkg::KBS_END;
  endproperty
  a_frame: assert property (p_frame) else $error("frame error missed");

  property p_direct_pins;
    @(posedge clk) disable iff (rst)
    (state == kbs_pkg::KBS_OFF) |=> chan_clock_pin_oe == ~$past(clken)
      && chan_data_pin_oe == ~$past(wdat);
  endproperty
  a_direct_pins: assert property (p_direct_pins) else $error("direct pins wrong");

  property p_direct_irq;
    @(posedge clk) disable iff (rst)
    (!ctl_en && ie_direct) |=> chan3_edge_irq == $past(clk_sync[2]);
  endproperty
  a_direct_irq: assert property (p_direct_irq) else $error("direct irq wrong");

  property p_tx_stop;
    @(posedge clk) disable iff (rst)
    (active_fall && ctl_xmt && edge_cnt == kbs_pkg::TX_STOP_EDGE) |=> ##1
      (chan_data_pin_oe & active_channel_field) == 3'h0;
  endproperty
  a_tx_stop: assert property (p_tx_stop) else $error("stop not high");

  c_rx_done: cover property (@(posedge clk) disable iff (rst) rx_stop);
  c_tx_done: cover property (@(posedge clk) disable iff (rst) tx_lc);
  c_two_start: cover property (@(posedge clk) disable iff (rst)
    start_take && start_hits[0] && start_hits[1]);
  c_abort_active: cover property (@(posedge clk) disable iff (rst) in_active && abort);

endmodule : kbs_shifter

// *** verif/kbs_link_dev.sv ***
// behavioural keyboard or pointing device on one channel of the two-wire link
`timescale 1ns/10ps
module kbs_link_dev (
  input wire logic clk_line,
  input wire logic dat_line,
  output logic clk_pull,
  output logic dat_pull
);
  localparam int HALF_NS = 100; // half of the 200 ns link clock
  logic aborted; // host held our clock low inside a frame
  // lines released: clock stands still high between frames
  initial begin
    clk_pull = 1'h0;
    dat_pull = 1'h0;
    aborted = 1'h0;
  end
  // device to host frame: start, eight data, parity, stop
  task automatic send(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    logic [10:0] frame;
    frame = {~bad_stop, (~^b) ^ bad_par, b, 1'h0};
    aborted = 1'h0;
    for (int i = 0; i < 11; i++) begin
      dat_pull = ~frame[i];
      #(HALF_NS / 2);
      // host inhibit: drop the frame, the host asks for a resend later
      if (!clk_line) begin
        aborted = 1'h1;
        break;
      end
      clk_pull = 1'h1;
      #(HALF_NS);
      clk_pull = 1'h0;
      #(HALF_NS / 2);
    end
    dat_pull = 1'h0;
  endtask : send
  // host to device frame; bits sampled late in the high phase, since the
  // host needs a few of its own cycles to react to each fall
  task automatic recv(output logic [7:0] b, output logic par, output logic stp);
    logic [9:0] got;
    got = 10'h000;
    for (int k = 1; k <= 11; k++) begin
      clk_pull = 1'h1;
      #(HALF_NS);
      clk_pull = 1'h0;
      #(HALF_NS - 10);
      // lsb arrives first, so shift in from the top
      if (k <= 10) begin
        got = {dat_line, got[9:1]};
      end
      // line-control bit: data low across the last fall
      if (k == 10) begin
        dat_pull = 1'h1;
      end
      #10;
    end
    #(HALF_NS);
    dat_pull = 1'h0;
    {stp, par, b} = got;
  endtask : recv
endmodule : kbs_link_dev

// *** verif/testbench.sv ***
// self-checking bench for the shift engine with three device models
`timescale 1ns/10ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin err_total++; \
  $display("mismatch at %0t: got %h expected %h", $time, g, e); end end
module testbench;
  typedef struct packed {
    logic [1:0] ch;
    logic [7:0] b;
    logic bp;
    logic bs;
    logic [7:0] oc;
    logic [7:0] ie;
  } kbs_row_t;
  logic clk;
  logic rst;
  logic [2:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic [2:0] clk_oe; // engine pulls clock low
  logic [2:0] dat_oe; // engine pulls data low
  logic [2:0] irq; // ch3, ch2, engine or ch1
  logic [2:0] clk_out; // open-drain level, only ever low
  logic [2:0] dat_out;
  wire [2:0] dev_clk; // device pulls
  wire [2:0] dev_dat;
  wire [2:0] clk_line = ~(clk_oe | dev_clk); // open drain with pull-up
  wire [2:0] dat_line = ~(dat_oe | dev_dat);
  int err_total;
  int n_checks;
  logic [7:0] rv;
  logic [7:0] ex;
  logic [7:0] tb_b;
  logic tb_p;
  logic tb_s;
  // receive rows: channel, byte, bad parity, low stop, output control, irq enables
  kbs_row_t rows [4] = '{
    '{2'h1, 8'h00, 1'h0, 1'h0, 8'h3f, 8'h03},
    '{2'h2, 8'hff, 1'h1, 1'h0, 8'h17, 8'h02},
    '{2'h3, 8'h5a, 1'h0, 1'h1, 8'h27, 8'h01},
    '{2'h3, 8'h81, 1'h1, 1'h1, 8'h3f, 8'h04}};
  // reset values, last address unmapped
  logic [2:0] ra [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h5, 3'h6};
  logic [7:0] rvals [6] = '{8'h00, 8'h00, 8'h00, 8'h07, 8'h00, 8'h00};
  kbs_shifter dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .chan_clock_pin_in(clk_line), .chan_clock_pin_out(clk_out), .chan_clock_pin_oe(clk_oe),
    .chan_data_pin_in(dat_line), .chan_data_pin_out(dat_out), .chan_data_pin_oe(dat_oe),
    .shifter_irq_line(irq[0]), .chan2_edge_irq(irq[1]), .chan3_edge_irq(irq[2]));
  kbs_link_dev dev1 (.clk_line(clk_line[0]), .dat_line(dat_line[0]),
    .clk_pull(dev_clk[0]), .dat_pull(dev_dat[0]));
  kbs_link_dev dev2 (.clk_line(clk_line[1]), .dat_line(dat_line[1]),
    .clk_pull(dev_clk[1]), .dat_pull(dev_dat[1]));
  kbs_link_dev dev3 (.clk_line(clk_line[2]), .dat_line(dat_line[2]),
    .clk_pull(dev_clk[2]), .dat_pull(dev_dat[2]));
  // 40 MHz system clock
  initial begin
    clk = 1'h0;
    forever #12.5 clk = ~clk;
  end
  // closing report, also reached when a wait runs out
  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : finish_test
  // one-cycle write strobe
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask : wr
  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask : rd
  task automatic rchk(input logic [2:0] a, input logic [7:0] e);
    rd(a, rv);
    `CHK(rv, e)
  endtask : rchk
  // let registered pin enables settle
  task automatic settle();
    repeat (3) @(posedge clk);
    #1;
  endtask : settle
  // bounded poll of one status bit
  task automatic poll(input int bitn);
    for (int i = 0; i < 300; i++) begin
      rd(kbs_pkg::ADDR_STATUS, rv);
      if (rv[bitn] === 1'h1) begin
        return;
      end
    end
    err_total++;
    $display("mismatch at %0t: got %h expected %h", $time, rv, 8'h03);
    finish_test();
  endtask : poll
  // restart in receive mode, then open the chosen channels
  task automatic setup_rx(input logic [7:0] oc, input logic [7:0] ie);
    wr(kbs_pkg::ADDR_CONTROL, 8'h00);
    wr(kbs_pkg::ADDR_OUTCTL, 8'h07);
    wr(kbs_pkg::ADDR_IRQEN, ie);
    wr(kbs_pkg::ADDR_CONTROL, 8'h01);
    settle();
    `CHK(clk_oe, 3'h7)
    wr(kbs_pkg::ADDR_OUTCTL, oc);
    settle();
    `CHK(clk_oe, ~oc[5:3])
  endtask : setup_rx
  task automatic dev_send(input logic [1:0] ch, input logic [7:0] b, input logic bp,
                          input logic bs);
    case (ch)
      2'h1: dev1.send(b, bp, bs);
      2'h2: dev2.send(b, bp, bs);
      default: dev3.send(b, bp, bs);
    endcase
  endtask : dev_send
  // main sequence
  initial begin
    rst = 1'h1;
    reg_addr = 3'h0;
    reg_wdata = 8'h00;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
    err_total = 0;
    n_checks = 0;
    repeat (16) @(posedge clk);
    rst <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      rchk(ra[i], rvals[i]);
    end
    // status is read only
    wr(kbs_pkg::ADDR_STATUS, 8'hff);
    rchk(kbs_pkg::ADDR_STATUS, 8'h00);
    // plain receive frames, errors and irq masks from the table
    foreach (rows[i]) begin
      setup_rx(rows[i].oc, rows[i].ie);
      dev_send(rows[i].ch, rows[i].b, rows[i].bp, rows[i].bs);
      poll(kbs_pkg::ST_DONE);
      ex = {1'h0, rows[i].bs, 3'h1 << (rows[i].ch - 2'h1), rows[i].bp, 2'h3};
      rchk(kbs_pkg::ADDR_STATUS, ex);
      rchk(kbs_pkg::ADDR_BYTE, rows[i].b);
      `CHK(irq[0], |rows[i].ie[1:0])
      `CHK(clk_oe, 3'h7)
    end
    // simultaneous starts: channel 1 wins, channel 2 inhibited
    setup_rx(8'h3f, 8'h03);
    fork
      dev1.send(8'h3c, 1'h0, 1'h0);
      dev2.send(8'hc3, 1'h0, 1'h0);
      begin
        repeat (40) @(posedge clk);
        #1;
        `CHK(clk_oe, 3'h6)
      end
    join
    poll(kbs_pkg::ST_DONE);
    rchk(kbs_pkg::ADDR_STATUS, 8'h0b);
    rchk(kbs_pkg::ADDR_BYTE, 8'h3c);
    `CHK(dev2.aborted, 1'h1)
    // abort in mid reception by clearing every channel enable
    setup_rx(8'h27, 8'h01);
    fork
      dev3.send(8'h11, 1'h0, 1'h0);
      begin
        poll(kbs_pkg::ST_START);
        `CHK(irq[0], 1'h1)
        wr(kbs_pkg::ADDR_OUTCTL, 8'h07);
        rchk(kbs_pkg::ADDR_STATUS, 8'h00);
      end
    join
    `CHK(dev3.aborted, 1'h1)
    // transmit on channel 1
    wr(kbs_pkg::ADDR_CONTROL, 8'h00);
    wr(kbs_pkg::ADDR_OUTCTL, 8'h07);
    wr(kbs_pkg::ADDR_CONTROL, 8'h03);
    settle();
    `CHK({clk_oe, dat_oe}, 6'h38)
    wr(kbs_pkg::ADDR_BYTE, 8'ha7);
    wr(kbs_pkg::ADDR_OUTCTL, 8'h06);
    wr(kbs_pkg::ADDR_OUTCTL, 8'h0e);
    settle();
    `CHK({clk_oe, dat_oe}, 6'h31)
    dev1.recv(tb_b, tb_p, tb_s);
    `CHK(tb_b, 8'ha7)
    `CHK(tb_p, 1'h0)
    `CHK(tb_s, 1'h1)
    poll(kbs_pkg::ST_DONE);
    rchk(kbs_pkg::ADDR_STATUS, 8'h0b);
    rchk(kbs_pkg::ADDR_OUTCTL, 8'h0f);
    `CHK({clk_oe, dat_oe}, 6'h38)
    // abort from transmit idle, firmware restoring the data outs
    wr(kbs_pkg::ADDR_OUTCTL, 8'h06);
    wr(kbs_pkg::ADDR_OUTCTL, 8'h0e);
    wr(kbs_pkg::ADDR_OUTCTL, 8'h07);
    settle();
    `CHK({clk_oe, dat_oe}, 6'h38)
    rchk(kbs_pkg::ADDR_STATUS, 8'h00);
    // engine off: bits drive pins, clocks routed to irqs
    wr(kbs_pkg::ADDR_CONTROL, 8'h00);
    wr(kbs_pkg::ADDR_IRQEN, 8'h04);
    wr(kbs_pkg::ADDR_OUTCTL, 8'h2a);
    settle();
    `CHK({clk_oe, dat_oe}, 6'h15)
    rchk(kbs_pkg::ADDR_INREAD, 8'h2a);
    `CHK(irq, 3'h5)
    `CHK({clk_out, dat_out}, 6'h00)
    finish_test();
  end
endmodule : testbench
